// [common/pofc_pkg.sv]
/*
 * Constants for the operand and result format selection block of the
 * public key engine: register offsets, field positions, reset values.
 * Assumes an AXI4-Lite master with 32-bit data and one clock domain.
 */
// Notes on behaviour
// - First operand affine bit set: point is affine, else Jacobian; curve operations only.
// - First operand Montgomery bit set: data already Montgomery form, else normal form.
// - Second operand affine bit set: point is affine, else Jacobian; curve operations only.
// - Second operand Montgomery bit set: data in Montgomery form, else normal form.
// - Modular multiply in a curve operation converts any operand with affine bit clear to Jacobian first.
// - Modular multiply converts any operand with Montgomery bit clear to Montgomery first.
// - Result affine bit set: result point affine, else Jacobian; curve operations only.
// - Result Montgomery bit set: result Montgomery form, else normal form.
package pofc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] FMT_SEL_OFFSET = 16'h2050;
  localparam logic [15:0] RUN_CTRL_OFFSET = 16'h2054;
  localparam logic [15:0] STATUS_OFFSET = 16'h2058;
  localparam logic [7:0] FMT_SEL_RESET = 8'h2A;
  localparam int FMT_WIDTH = 6;
  // ****************************************
  // Field positions in the format byte
  // ****************************************
  localparam int FIRST_AFF_BIT = 0;
  localparam int FIRST_MON_BIT = 1;
  localparam int SECOND_AFF_BIT = 2;
  localparam int SECOND_MON_BIT = 3;
  localparam int RESULT_AFF_BIT = 4;
  localparam int RESULT_MON_BIT = 5;
  // Run control: bit 0 start, bit 1 curve operation, bit 2 modular multiply.
  localparam int RUN_START_BIT = 0;
  localparam int RUN_CURVE_BIT = 1;
  localparam int RUN_MULT_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Default run length of an operation in cycles.
  localparam int RUN_CYCLES_DEFAULT = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_RUN, ST_DELIVER} pofc_state_t;
endpackage

// [hw/pofc_top.sv]
/*
 * Format selection register and the operand/result format steering of the
 * public key engine, with an AXI4-Lite slave and a small operation sequencer.
 * Assumes one 250 MHz clock, synchronous active-low reset, synchronous inputs.
 */
`timescale 1ns/1ps
module pofc_top import pofc_pkg::*; #(
  parameter int RUN_CYCLES = RUN_CYCLES_DEFAULT
) (
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address and data
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Format steering towards the arithmetic datapath, then engine busy and done
  output logic first_point_operand_to_jacobian,
  output logic first_point_operand_to_montgomery,
  output logic second_point_operand_to_jacobian,
  output logic second_point_operand_to_montgomery,
  output logic result_deliver_affine,
  output logic result_deliver_montgomery,
  output logic engine_busy,
  output logic engine_done
);
  // The run counter is 16 bits wide, so longer runs cannot be counted.
  if (RUN_CYCLES < 1 || RUN_CYCLES > 65535) begin : g_bad_run_cycles
    $error("RUN_CYCLES out of range");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic [15:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] fmt;
    logic [FMT_WIDTH-1:0] latched;
    logic op_curve;
    logic op_mult;
    pofc_state_t state;
    logic [15:0] count;
    logic conv_first_jac;
    logic conv_first_mon;
    logic conv_second_jac;
    logic conv_second_mon;
    logic out_aff;
    logic out_mon;
    logic busy;
    logic done;
  } pofc_st_t;

  pofc_st_t st_reg;
  pofc_st_t st_next;
  logic start_req;

  // One write and one read are handled at a time; address and data are taken in either order.
  always_comb begin
    st_next = st_reg;
    start_req = 1'b0;
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.awaddr = s_axi_awaddr;
      st_next.aw_have = 1'b1;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
      st_next.w_have = 1'b1;
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if ({st_reg.awaddr[15:2], 2'b00} == FMT_SEL_OFFSET) begin
        // Changes during a run only affect the next operation.
        if (st_reg.wstrb[0]) begin
          st_next.fmt = {2'b00, st_reg.wdata[5:0]};
        end
      end else if ({st_reg.awaddr[15:2], 2'b00} == RUN_CTRL_OFFSET) begin
        if (st_reg.wstrb[0] && st_reg.wdata[RUN_START_BIT]) begin
          start_req = 1'b1;
        end
      end else if ({st_reg.awaddr[15:2], 2'b00} != STATUS_OFFSET) begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    // Read channel: the answer comes one cycle after the address is taken.
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = 32'h0000_0000;
      if ({s_axi_araddr[15:2], 2'b00} == FMT_SEL_OFFSET) begin
        st_next.rdata = {24'h00_0000, st_reg.fmt};
      end else if ({s_axi_araddr[15:2], 2'b00} == STATUS_OFFSET) begin
        st_next.rdata = {22'h0, st_reg.done, st_reg.busy, 2'b00, st_reg.latched};
      end else if ({s_axi_araddr[15:2], 2'b00} != RUN_CTRL_OFFSET) begin
        st_next.rresp = RESP_SLVERR;
      end
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end
    // Operation sequencer.
    case (st_reg.state)
      ST_IDLE: begin
        if (start_req) begin
          // Snapshot of the format byte for the whole operation.
          st_next.latched = st_reg.fmt[FMT_WIDTH-1:0];
          // The kind is taken only here, so a start written during a run cannot alter it.
          st_next.op_curve = st_reg.wdata[RUN_CURVE_BIT];
          st_next.op_mult = st_reg.wdata[RUN_MULT_BIT];
          st_next.busy = 1'b1;
          st_next.done = 1'b0;
          st_next.state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        // Affine bits count only for curve work; the multiply converts non-affine to Jacobian.
        st_next.conv_first_jac = st_reg.op_mult && st_reg.op_curve && !st_reg.latched[FIRST_AFF_BIT];
        st_next.conv_second_jac = st_reg.op_mult && st_reg.op_curve && !st_reg.latched[SECOND_AFF_BIT];
        // For a multiply, normal-form inputs are brought into Montgomery form first.
        st_next.conv_first_mon = st_reg.op_mult && !st_reg.latched[FIRST_MON_BIT];
        st_next.conv_second_mon = st_reg.op_mult && !st_reg.latched[SECOND_MON_BIT];
        st_next.count = 16'(RUN_CYCLES - 1);
        st_next.state = ST_RUN;
      end
      ST_RUN: begin
        if (st_reg.count == 16'h0000) begin
          st_next.state = ST_DELIVER;
        end else begin
          st_next.count = st_reg.count - 16'h0001;
        end
      end
      ST_DELIVER: begin
        // Result coordinates only apply to curve work; form always applies.
        st_next.out_aff = st_reg.op_curve && st_reg.latched[RESULT_AFF_BIT];
        st_next.out_mon = st_reg.latched[RESULT_MON_BIT];
        st_next.conv_first_jac = 1'b0;
        st_next.conv_first_mon = 1'b0;
        st_next.conv_second_jac = 1'b0;
        st_next.conv_second_mon = 1'b0;
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.state = ST_IDLE;
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  // State register; the enable freezes everything.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.fmt <= FMT_SEL_RESET;
      st_reg.latched <= FMT_SEL_RESET[FMT_WIDTH-1:0];
      st_reg.state <= ST_IDLE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign first_point_operand_to_jacobian = st_reg.conv_first_jac;
  assign first_point_operand_to_montgomery = st_reg.conv_first_mon;
  assign second_point_operand_to_jacobian = st_reg.conv_second_jac;
  assign second_point_operand_to_montgomery = st_reg.conv_second_mon;
  assign result_deliver_affine = st_reg.out_aff;
  assign result_deliver_montgomery = st_reg.out_mon;
  assign engine_busy = st_reg.busy;
  assign engine_done = st_reg.done;

  // ****************************************
  // Checks
  // ****************************************
  a_latch_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state != ST_IDLE) |=> $stable(st_reg.latched))
    else $error("format snapshot changed during an operation");
  a_first_mon_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_CONVERT && st_reg.op_mult && !st_reg.latched[FIRST_MON_BIT])
      |=> first_point_operand_to_montgomery)
    else $error("first operand not converted to Montgomery form");
  a_second_mon_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_CONVERT) |=>
      second_point_operand_to_montgomery == ($past(st_reg.op_mult) && !$past(st_reg.latched[SECOND_MON_BIT])))
    else $error("second operand Montgomery steering wrong");
  a_first_jac_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_CONVERT) |=> first_point_operand_to_jacobian ==
      ($past(st_reg.op_mult) && $past(st_reg.op_curve) && !$past(st_reg.latched[FIRST_AFF_BIT])))
    else $error("first operand Jacobian steering wrong");
  a_second_jac_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_CONVERT && !st_reg.op_curve) |=> !second_point_operand_to_jacobian)
    else $error("affine steering used outside curve work");
  a_first_aff_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_CONVERT && st_reg.latched[FIRST_AFF_BIT]) |=> !first_point_operand_to_jacobian)
    else $error("affine first operand converted");
  a_result_aff: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_DELIVER) |=>
      result_deliver_affine == ($past(st_reg.op_curve) && $past(st_reg.latched[RESULT_AFF_BIT])))
    else $error("result coordinate selection wrong");
  a_result_mon: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_DELIVER) |=> result_deliver_montgomery == $past(st_reg.latched[RESULT_MON_BIT]))
    else $error("result form selection wrong");
  a_first_mon_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && st_reg.state == ST_CONVERT && st_reg.latched[FIRST_MON_BIT]) |=> !first_point_operand_to_montgomery)
    else $error("Montgomery first operand converted");
endmodule

// [dv/pofc_top_bench.sv]
/* Self-checking bench for pofc_top: format register over AXI4-Lite and operation steering.
   Assumes pofc_pkg; the bench drives every port itself and drops clk_en for three cycles in each operation. */
`timescale 1ns/1ps
module pofc_top_bench import pofc_pkg::*; ;
  // ****************************************
  // Signals and the design
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, done_seen = 1'b0;
  logic clk_en = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic res_aff, res_mon, engine_busy, engine_done;
  wire [3:0] steer;
  logic [33:0] read_q[$], done_q[$];
  logic [2:0] kinds[8] = '{3'h1, 3'h3, 3'h5, 3'h7, 3'h7, 3'h5, 3'h3, 3'h1};
  int fails = 0, checks = 0;
  int seed = 32'hAA27;

  // A run length of 8 keeps both in-run writes inside the operation.
  pofc_top #(.RUN_CYCLES(8)) u_dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .first_point_operand_to_jacobian(steer[3]), .first_point_operand_to_montgomery(steer[2]),
    .second_point_operand_to_jacobian(steer[1]), .second_point_operand_to_montgomery(steer[0]),
    .result_deliver_affine(res_aff), .result_deliver_montgomery(res_mon), .engine_busy, .engine_done);

  // The 250 MHz clock.
  always #2 aclk = ~aclk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data are offered together; each drops at the edge that takes it.
  task automatic wr(input logic [15:0] a, input logic [31:0] dv, input logic [3:0] s, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({s_axi_bresp, 32'h0}, {r, 32'h0});
  endtask

  // The expected word is noted first; the watcher compares it on the handshake.
  task automatic rd(input logic [15:0] a, input logic [33:0] e);
    read_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // One operation of kind k with a random format, rewritten while it runs.
  task automatic op(input logic [2:0] k);
    logic [5:0] f;
    logic j;
    f = 6'($random(seed));
    j = k[1] & k[2];
    wr(FMT_SEL_OFFSET, {26'h0, f}, 4'hF, RESP_OKAY);
    done_q.push_back({32'h0, k[1] & f[4], f[5]});
    wr(RUN_CTRL_OFFSET, {29'h0, k}, 4'hF, RESP_OKAY);
    @(negedge aclk);
    chk({29'h0, engine_busy, steer}, {29'h0, 1'b1, j & ~f[0], k[2] & ~f[1], j & ~f[2], k[2] & ~f[3]});
    @(posedge aclk);
    wr(FMT_SEL_OFFSET, {26'h0, ~f}, 4'hF, RESP_OKAY);
    // A second start with the other kind must be ignored while the run goes on.
    wr(RUN_CTRL_OFFSET, {29'h0, ~k[2:1], 1'b1}, 4'hF, RESP_OKAY);
    // Freeze the block while the bus is idle; done would otherwise have risen by now.
    clk_en <= 1'b0;
    repeat (3) @(posedge aclk);
    clk_en <= 1'b1;
    chk({33'h0, engine_done}, 34'h0);
    for (int n = 0; n < 100 && !engine_done; n++) @(posedge aclk);
    chk({33'h0, engine_done}, 34'h1);
    rd(STATUS_OFFSET, {RESP_OKAY, 22'h0, 2'b10, 2'b00, f});
    rd(FMT_SEL_OFFSET, {RESP_OKAY, 26'h0, ~f});
    $display("test operation %b done", k);
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // Processes
  // ****************************************
  // Watcher: read data on each handshake, result form on each rise of done.
  // Error reads carry no defined data, so only their response is compared.
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rresp == RESP_SLVERR ? 32'h0 : s_axi_rdata}, read_q.pop_front());
    if (engine_done && !done_seen)
      chk({32'h0, res_aff, res_mon}, done_q.pop_front());
    done_seen <= engine_done;
  end

  // Watchdog: the whole sequence needs a few hundred cycles at most.
  initial begin
    #20000;
    fails++;
    finish_test();
  end

  // Main sequence: reset, register accesses, then every operation kind.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({26'h0, engine_busy, engine_done, steer, res_aff, res_mon}, 34'h0);
    rd(FMT_SEL_OFFSET, {RESP_OKAY, 24'h0, FMT_SEL_RESET});
    d = $random(seed);
    wr(FMT_SEL_OFFSET, d, 4'hF, RESP_OKAY);
    rd(FMT_SEL_OFFSET, {RESP_OKAY, 26'h0, d[5:0]});
    wr(FMT_SEL_OFFSET, ~d, 4'hE, RESP_OKAY);
    rd(FMT_SEL_OFFSET, {RESP_OKAY, 26'h0, d[5:0]});
    wr(16'h2060, d, 4'hF, RESP_SLVERR);
    rd(16'h2060, {RESP_SLVERR, 32'h0});
    $display("test registers done");
    foreach (kinds[i]) op(kinds[i]);
    repeat (2) @(posedge aclk);
    finish_test();
  end
endmodule
